/* rtl/fault_rec_consts.vh */
// Constants for the context fault recorder: field positions, reset values, widths.
// Included by the recorder module; defines only.
`ifndef FAULT_REC_CONSTS_VH
`define FAULT_REC_CONSTS_VH
// Fault status field positions
`define FS_TF      0
`define FS_AFF     1
`define FS_PF      2
`define FS_EF      3
`define FS_TLBMCF  4
`define FS_TLBLKF  5
`define FS_ASF     6
`define FS_UUT     7
`define FS_SS      30
`define FS_MULTI   31
// Stall status (bit 30) is left out of the clear mask, never cleared by a status write
`define FS_W1C_MASK 32'h800000FF
// Syndrome field positions
`define SYN_WNR    4
`define SYN_WALK_FAULT_FLAG   10
`define SYN_AFR    11
// Fault type codes on the fault input
`define FT_TRANS   3'h0
`define FT_PERM    3'h1
`define FT_EXT     3'h2
`define FT_UUT     3'h3
`define FT_ASIZE   3'h4
// External fault recording modes
`define EXT_SYNC   2'h0
`define EXT_ASYNC  2'h1
`define EXT_NONE   2'h2
// Address limits and reset values
`define VA32_BITS  32
`define PA40_BITS  40
`define TTB_BITS   48
`define RST_ZERO32 32'h00000000
`define RST_ZERO64 64'h0000000000000000
`endif

/* rtl/context_fault_recorder.v */
// Context fault recorder: address range checks and per-bank fault records.
// Assumes one fault event per cycle, inputs synchronous to CLK_IN, software
// accesses presented as single-cycle strobes on plain ports.
`timescale 1ns/100ps
`include "fault_rec_consts.vh"
module context_fault_recorder #(
    parameter NUM_BANKS  = 8,
    parameter BANK_W     = 3,
    parameter EXT_MODE   = 0,
    parameter CFG_FAULT  = 0
) (
    // Clock and reset
    input  wire                  CLK_IN,
    input  wire                  RST_B_IN,
    // Fault event from the translation pipeline
    input  wire                  FAULT_VALID_IN,
    input  wire [2:0]            FAULT_TYPE_IN,
    input  wire                  FAULT_WALK_IN,
    input  wire                  FAULT_WRITE_IN,
    input  wire                  STAGE2_FAULT_IN,
    input  wire [BANK_W-1:0]     S1_BANK_IN,
    input  wire [BANK_W-1:0]     S2_BANK_IN,
    input  wire [63:0]           FAULT_ADDR_IN,
    input  wire [31:0]           FAULT_RSYN_IN,
    // Address check request for the addressed bank
    input  wire                  CHECK_VALID_IN,
    input  wire [BANK_W-1:0]     CHECK_BANK_IN,
    input  wire                  CHECK_STAGE2_IN,
    input  wire [1:0]            CHECK_KIND_IN,
    input  wire [63:0]           CHECK_ADDR_IN,
    input  wire [5:0]            IPA_SIZE_IN,
    input  wire [5:0]            PA_SIZE_IN,
    input  wire [5:0]            OUT_SIZE_IN,
    // Per-bank configuration, packed by bank
    input  wire [NUM_BANKS-1:0]  TRANSLATION_ENABLE_IN,
    input  wire [NUM_BANKS-1:0]  WIDE_VA_FORMAT_IN,
    input  wire [NUM_BANKS-1:0]  HYPERVISOR_CONTEXT_IN,
    input  wire [NUM_BANKS-1:0]  MONITOR_CONTEXT_IN,
    input  wire [NUM_BANKS-1:0]  FAULT_ABORT_REPORT_ENABLE_IN,
    input  wire [NUM_BANKS-1:0]  FAULT_INTERRUPT_ENABLE_IN,
    input  wire [NUM_BANKS*6-1:0] SIGN_EXTENSION_POSITION_IN,
    input  wire [NUM_BANKS*6-1:0] REGION0_SIZE_IN,
    input  wire [NUM_BANKS*6-1:0] REGION1_SIZE_IN,
    // Software access to records
    input  wire                  SW_WR_IN,
    input  wire                  SW_RD_IN,
    input  wire                  SW_NONSECURE_IN,
    input  wire [7:0]            SW_BANK_IN,
    input  wire [31:0]           SW_WDATA_IN,
    input  wire [7:0]            NONSECURE_BANK_COUNT_IN,
    // Results
    output reg                   CHECK_TFAULT_OUT,
    output reg                   CHECK_ASFAULT_OUT,
    output reg                   ABORT_OUT,
    output reg  [NUM_BANKS-1:0]  BANK_IRQ_OUT,
    output reg  [31:0]           RD_STATUS_OUT,
    output reg  [63:0]           RD_ADDR_OUT,
    output reg  [31:0]           RD_SYN_OUT,
    output reg  [31:0]           RD_RSYN_OUT,
    output reg                   CFG_ACCESS_FAULT_OUT,
    output reg  [7:0]            IMPLEMENTED_BANK_COUNT_OUT
);

    localparam [1:0] KIND_INPUT = 2'h0;
    localparam [1:0] KIND_OUT   = 2'h1;
    localparam [1:0] KIND_TTB0  = 2'h2;
    localparam [1:0] KIND_TTB1  = 2'h3;

    reg [31:0] status_reg   [0:NUM_BANKS-1];
    reg [63:0] address_reg  [0:NUM_BANKS-1];
    reg [31:0] syndrome_reg [0:NUM_BANKS-1];
    reg [31:0] rsyn_reg     [0:NUM_BANKS-1];

    // Bit-count limit: address exceeds n bits
    function over;
        input [63:0] a;
        input [6:0]  n;
        begin
            over = (n >= 7'd64) ? 1'b0 : ((a >> n) != 64'h0);
        end
    endfunction

    function [6:0] min7;
        input [6:0] a;
        input [6:0] b;
        begin
            min7 = (a < b) ? a : b;
        end
    endfunction

    // Address checks
    wire [BANK_W-1:0] cb     = CHECK_BANK_IN;
    wire              c_en   = TRANSLATION_ENABLE_IN[cb];
    wire              c_wide = WIDE_VA_FORMAT_IN[cb];
    wire [6:0] sign_extension_position   = {1'b0, SIGN_EXTENSION_POSITION_IN[cb*6 +: 6]};
    wire [6:0] r0    = 7'd64 - {1'b0, REGION0_SIZE_IN[cb*6 +: 6]};
    wire [6:0] r1    = 7'd64 - {1'b0, REGION1_SIZE_IN[cb*6 +: 6]};
    wire [6:0] ipa_n = {1'b0, IPA_SIZE_IN};
    wire [6:0] pa_n  = {1'b0, PA_SIZE_IN};
    wire [6:0] out_n = {1'b0, OUT_SIZE_IN};
    wire       upper = CHECK_ADDR_IN[63];
    wire       skip_sep = HYPERVISOR_CONTEXT_IN[cb] | MONITOR_CONTEXT_IN[cb];
    wire [63:0] sep_hi = CHECK_ADDR_IN >> (sign_extension_position + 7'd1);
    wire [63:0] sep_ones = {64{1'b1}} >> (sign_extension_position + 7'd1);
    wire        sep_bad = !skip_sep && (sep_hi != 64'h0) && (sep_hi != sep_ones);
    wire [63:0] va_reg = upper ? ~CHECK_ADDR_IN : CHECK_ADDR_IN;
    wire        region_bad = over(va_reg, upper ? r1 : r0);
    reg         tfault_next;
    reg         asfault_next;
    reg [6:0]   lim;

    always @* begin
        tfault_next  = 1'b0;
        asfault_next = 1'b0;
        lim          = 7'd64;
        if (CHECK_KIND_IN == KIND_INPUT) begin
            if (!c_wide) begin
                tfault_next = CHECK_STAGE2_IN ? over(CHECK_ADDR_IN, ipa_n)
                                              : over(CHECK_ADDR_IN, 7'd`VA32_BITS);
            end else if (c_en) begin
                tfault_next = CHECK_STAGE2_IN ? over(CHECK_ADDR_IN, min7(ipa_n, r0))
                                              : (sep_bad | region_bad);
            end
            // Wide format with translation off checks nothing
        end else begin
            // Stage 2 banks check only the first table base
            if (!(CHECK_STAGE2_IN && CHECK_KIND_IN == KIND_TTB1)) begin
                if (!c_wide) begin
                    lim = 7'd`PA40_BITS;
                end else begin
                    lim = CHECK_STAGE2_IN ? out_n : ipa_n;
                    if (c_en)
                        lim = min7(lim, pa_n);
                end
                if (CHECK_KIND_IN != KIND_OUT)
                    asfault_next = over(CHECK_ADDR_IN, min7(lim, 7'd`TTB_BITS));
                else
                    asfault_next = over(CHECK_ADDR_IN, lim);
            end
        end
    end

    // Fault recording decision
    wire [BANK_W-1:0] fb = STAGE2_FAULT_IN ? S2_BANK_IN : S1_BANK_IN;
    wire is_ext = (FAULT_TYPE_IN == `FT_EXT);
    wire is_uut = (FAULT_TYPE_IN == `FT_UUT);
    wire [1:0] ext_mode = FAULT_WALK_IN ? `EXT_SYNC : EXT_MODE[1:0];
    wire rec = FAULT_VALID_IN && !(is_ext && ext_mode == `EXT_NONE);
    wire async_rec = is_ext && ext_mode == `EXT_ASYNC;
    reg  [31:0] fs_bit;

    always @* begin
        case (FAULT_TYPE_IN)
            `FT_TRANS: fs_bit = 32'h1 << `FS_TF;
            `FT_PERM:  fs_bit = 32'h1 << `FS_PF;
            `FT_EXT:   fs_bit = 32'h1 << `FS_EF;
            `FT_UUT:   fs_bit = 32'h1 << `FS_UUT;
            `FT_ASIZE: fs_bit = 32'h1 << `FS_ASF;
            default:   fs_bit = 32'h1 << `FS_TF;
        endcase
    end

    wire sw_impl = (SW_BANK_IN < NUM_BANKS) &&
                   !(SW_NONSECURE_IN && SW_BANK_IN >= NONSECURE_BANK_COUNT_IN);
    wire [BANK_W-1:0] sb = SW_BANK_IN[BANK_W-1:0];

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g = g + 1) begin : bank
            wire hit = rec && (fb == g);
            wire clr = SW_WR_IN && sw_impl && (sb == g);
            wire [31:0] cleared = status_reg[g] & ~(clr ? (SW_WDATA_IN & `FS_W1C_MASK) : 32'h0);
            always @(posedge CLK_IN) begin
                if (!RST_B_IN) begin
                    status_reg[g]   <= `RST_ZERO32;
                    address_reg[g]  <= `RST_ZERO64;
                    syndrome_reg[g] <= `RST_ZERO32;
                    rsyn_reg[g]     <= `RST_ZERO32;
                    BANK_IRQ_OUT[g] <= 1'b0;
                end else begin
                    // Set wins over a same-cycle software clear
                    if (hit && status_reg[g] != 32'h0) begin
                        status_reg[g] <= cleared | (32'h1 << `FS_MULTI);
                    end else if (hit) begin
                        status_reg[g] <= cleared | fs_bit;
                        if (async_rec) begin
                            address_reg[g]  <= `RST_ZERO64;
                            syndrome_reg[g] <= (32'h1 << `SYN_AFR) |
                                               ({31'h0, FAULT_WALK_IN} << `SYN_WALK_FAULT_FLAG);
                        end else if (!is_uut) begin
                            address_reg[g]  <= FAULT_ADDR_IN;
                            syndrome_reg[g] <= ({31'h0, FAULT_WALK_IN} << `SYN_WALK_FAULT_FLAG) |
                                               ({31'h0, FAULT_WRITE_IN} << `SYN_WNR);
                            rsyn_reg[g]     <= FAULT_RSYN_IN;
                        end
                    end else begin
                        status_reg[g] <= cleared;
                    end
                    BANK_IRQ_OUT[g] <= FAULT_INTERRUPT_ENABLE_IN[g] &&
                                       ((status_reg[g] != 32'h0) || hit);
                end
            end
        end
    endgenerate

    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            CHECK_TFAULT_OUT           <= 1'b0;
            CHECK_ASFAULT_OUT          <= 1'b0;
            ABORT_OUT                  <= 1'b0;
            RD_STATUS_OUT              <= `RST_ZERO32;
            RD_ADDR_OUT                <= `RST_ZERO64;
            RD_SYN_OUT                 <= `RST_ZERO32;
            RD_RSYN_OUT                <= `RST_ZERO32;
            CFG_ACCESS_FAULT_OUT       <= 1'b0;
            IMPLEMENTED_BANK_COUNT_OUT <= 8'h00;
        end else begin
            CHECK_TFAULT_OUT  <= CHECK_VALID_IN && tfault_next;
            CHECK_ASFAULT_OUT <= CHECK_VALID_IN && asfault_next;
            // Only unsupported transactions abort; other fault types never raise ABORT_OUT
            ABORT_OUT <= FAULT_VALID_IN && is_uut && FAULT_ABORT_REPORT_ENABLE_IN[fb];
            IMPLEMENTED_BANK_COUNT_OUT <= NUM_BANKS[7:0];
            CFG_ACCESS_FAULT_OUT <= (SW_RD_IN || SW_WR_IN) && !sw_impl
                                    && (CFG_FAULT != 0);
            if (SW_RD_IN) begin
                // Unimplemented or hidden banks read as zero
                RD_STATUS_OUT <= sw_impl ? status_reg[sb]   : `RST_ZERO32;
                RD_ADDR_OUT   <= sw_impl ? address_reg[sb]  : `RST_ZERO64;
                RD_SYN_OUT    <= sw_impl ? syndrome_reg[sb] : `RST_ZERO32;
                RD_RSYN_OUT   <= (sw_impl && !SW_NONSECURE_IN) ? rsyn_reg[sb] : `RST_ZERO32;
            end
        end
    end
endmodule

/* verification/fault_rec_sva.sv */
// Port checker for the context fault recorder.
// Bound from the bench top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module fault_rec_sva #(
    parameter NUM_BANKS = 8,
    parameter BANK_W    = 3
) (
    input wire                 CLK_IN,
    input wire                 RST_B_IN,
    input wire                 FAULT_VALID_IN,
    input wire [2:0]           FAULT_TYPE_IN,
    input wire                 STAGE2_FAULT_IN,
    input wire [BANK_W-1:0]    S1_BANK_IN,
    input wire [BANK_W-1:0]    S2_BANK_IN,
    input wire                 CHECK_VALID_IN,
    input wire [BANK_W-1:0]    CHECK_BANK_IN,
    input wire                 CHECK_STAGE2_IN,
    input wire [1:0]           CHECK_KIND_IN,
    input wire [63:0]          CHECK_ADDR_IN,
    input wire [NUM_BANKS-1:0] TRANSLATION_ENABLE_IN,
    input wire [NUM_BANKS-1:0] WIDE_VA_FORMAT_IN,
    input wire [NUM_BANKS-1:0] FAULT_ABORT_REPORT_ENABLE_IN,
    input wire [NUM_BANKS-1:0] FAULT_INTERRUPT_ENABLE_IN,
    input wire                 SW_WR_IN,
    input wire                 CHECK_TFAULT_OUT,
    input wire                 CHECK_ASFAULT_OUT,
    input wire                 ABORT_OUT,
    input wire [NUM_BANKS-1:0] BANK_IRQ_OUT,
    input wire [7:0]           IMPLEMENTED_BANK_COUNT_OUT
);
    wire [BANK_W-1:0] fb  = STAGE2_FAULT_IN ? S2_BANK_IN : S1_BANK_IN;
    wire              ab  = FAULT_VALID_IN && FAULT_TYPE_IN == 3'h3 && FAULT_ABORT_REPORT_ENABLE_IN[fb];
    wire              nar = !WIDE_VA_FORMAT_IN[CHECK_BANK_IN];
    wire              in1 = CHECK_VALID_IN && CHECK_KIND_IN == 2'h0 && !CHECK_STAGE2_IN && nar;
    reg  [BANK_W-1:0] fb_q1;
    reg  [BANK_W-1:0] fb_q2;
    // Bank of a fault two cycles back, for the interrupt check
    always @(posedge CLK_IN) begin
        fb_q1 <= fb;
        fb_q2 <= fb_q1;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    property p_count; $past(RST_B_IN) |-> IMPLEMENTED_BANK_COUNT_OUT == NUM_BANKS; endproperty
    a_count: assert property (p_count) else $error("bank count wrong");
    property p_abort; ab |=> ABORT_OUT; endproperty
    a_abort: assert property (p_abort) else $error("abort missing");
    property p_noabort; ABORT_OUT |-> $past(ab); endproperty
    a_noabort: assert property (p_noabort) else $error("abort unexpected");
    property p_noin;
        CHECK_VALID_IN && CHECK_KIND_IN == 2'h0 && !nar && !TRANSLATION_ENABLE_IN[CHECK_BANK_IN]
        |=> !CHECK_TFAULT_OUT;
    endproperty
    a_noin: assert property (p_noin) else $error("input check while off");
    property p_vahi; in1 && |CHECK_ADDR_IN[63:32] |=> CHECK_TFAULT_OUT; endproperty
    a_vahi: assert property (p_vahi) else $error("wide input not faulted");
    property p_valo; in1 && ~|CHECK_ADDR_IN[63:32] |=> !CHECK_TFAULT_OUT; endproperty
    a_valo: assert property (p_valo) else $error("narrow input faulted");
    property p_oa40;
        CHECK_VALID_IN && CHECK_KIND_IN == 2'h1 && nar && |CHECK_ADDR_IN[63:40] |=> CHECK_ASFAULT_OUT;
    endproperty
    a_oa40: assert property (p_oa40) else $error("output size fault missing");
    property p_quiet; !CHECK_VALID_IN |=> !(CHECK_TFAULT_OUT || CHECK_ASFAULT_OUT); endproperty
    a_quiet: assert property (p_quiet) else $error("check result without request");
    property p_irq;
        FAULT_VALID_IN && FAULT_TYPE_IN != 3'h2 && FAULT_INTERRUPT_ENABLE_IN[fb] && !SW_WR_IN
        ##1 !SW_WR_IN |=> BANK_IRQ_OUT[fb_q2];
    endproperty
    a_irq: assert property (p_irq) else $error("bank interrupt missing");
endmodule

/* verification/client_master.sv */
// Upstream client model: presents one fault event, repeated n cycles.
// Called just after a rising edge; idle address lines show the inverse.
`timescale 1ns/100ps
module client_master (
    input  wire        clk,
    output reg         valid,
    output reg         walk,
    output reg         wr,
    output reg         s2,
    output reg  [2:0]  ftype,
    output reg  [2:0]  b1,
    output reg  [2:0]  b2,
    output reg  [63:0] addr,
    output reg  [31:0] rsyn
);
    initial {valid, walk, wr, s2, ftype, b1, b2, addr, rsyn} = '0;
    task issue(input [2:0] t, input w, input st2, input [2:0] x1, input [2:0] x2,
               input [63:0] a, input int n);
        @(posedge clk);
        #1;
        {ftype, walk, s2, b1, b2, addr} = {t, w, st2, x1, x2, a};
        wr = a[1];
        rsyn = ~a[63:32];
        valid = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        valid = 1'b0;
        addr = ~a;
        rsyn = a[63:32];
    endtask
endmodule

/* verification/test_context_fault_recorder.sv */
// Bench for the context fault recorder with a client model and record model.
// Built with async recording of non-walk external faults and quiet refusals.
`timescale 1ns/100ps
module test_context_fault_recorder;
    logic        clk = 1'b0, rst_b = 1'b0, chk_v = 1'b0, chk_s2 = 1'b0;
    logic        sw_wr = 1'b0, sw_rd = 1'b0, sw_ns = 1'b0;
    logic [2:0]  chk_b = 3'h0;
    logic [1:0]  chk_k = 2'h0;
    logic [63:0] chk_a = 64'h0, m_ad[8] = '{default: 0};
    logic [5:0]  ipa = 6'h24, pa = 6'h30, osz = 6'h30;
    logic [7:0]  ten = 8'hFD, wide = 8'h02, hyp = 8'h0, mon = 8'h0, fare = 8'h20, fie = 8'hFF;
    logic [7:0]  sw_b = 8'h0, ns_cnt = 8'h8;
    logic [31:0] sw_d = 32'h0, seed = 32'hCC82;
    logic [31:0] m_st[8] = '{default: 0}, m_sy[8] = '{default: 0}, m_rs[8] = '{default: 0};
    logic [47:0] sign_extension_position = 48'h0, r0 = 48'h0, r1 = 48'h0;
    wire         f_v, f_w, f_wr, f_s2, tf, asf, abort_o, cfg_f;
    wire  [2:0]  f_t, f_b1, f_b2;
    wire  [63:0] f_a, rd_ad;
    wire  [31:0] f_rs, rd_st, rd_sy, rd_rs;
    wire  [7:0]  irq, nb;
    int          err_count = 0, num_checks = 0, bitpos[5] = '{0, 2, 3, 7, 6};
    always #12.5 clk = ~clk;
    client_master cli (.clk(clk), .valid(f_v), .walk(f_w), .wr(f_wr), .s2(f_s2), .ftype(f_t),
        .b1(f_b1), .b2(f_b2), .addr(f_a), .rsyn(f_rs));
    context_fault_recorder #(.NUM_BANKS(8), .BANK_W(3), .EXT_MODE(1), .CFG_FAULT(0)) DUT (
        .CLK_IN(clk), .RST_B_IN(rst_b), .FAULT_VALID_IN(f_v), .FAULT_TYPE_IN(f_t),
        .FAULT_WALK_IN(f_w), .FAULT_WRITE_IN(f_wr), .STAGE2_FAULT_IN(f_s2), .S1_BANK_IN(f_b1),
        .S2_BANK_IN(f_b2), .FAULT_ADDR_IN(f_a), .FAULT_RSYN_IN(f_rs), .CHECK_VALID_IN(chk_v),
        .CHECK_BANK_IN(chk_b), .CHECK_STAGE2_IN(chk_s2), .CHECK_KIND_IN(chk_k),
        .CHECK_ADDR_IN(chk_a), .IPA_SIZE_IN(ipa), .PA_SIZE_IN(pa), .OUT_SIZE_IN(osz),
        .TRANSLATION_ENABLE_IN(ten), .WIDE_VA_FORMAT_IN(wide), .HYPERVISOR_CONTEXT_IN(hyp),
        .MONITOR_CONTEXT_IN(mon), .FAULT_ABORT_REPORT_ENABLE_IN(fare),
        .FAULT_INTERRUPT_ENABLE_IN(fie), .SIGN_EXTENSION_POSITION_IN(sign_extension_position),
        .REGION0_SIZE_IN(r0), .REGION1_SIZE_IN(r1), .SW_WR_IN(sw_wr), .SW_RD_IN(sw_rd),
        .SW_NONSECURE_IN(sw_ns), .SW_BANK_IN(sw_b), .SW_WDATA_IN(sw_d),
        .NONSECURE_BANK_COUNT_IN(ns_cnt), .CHECK_TFAULT_OUT(tf), .CHECK_ASFAULT_OUT(asf),
        .ABORT_OUT(abort_o), .BANK_IRQ_OUT(irq), .RD_STATUS_OUT(rd_st), .RD_ADDR_OUT(rd_ad),
        .RD_SYN_OUT(rd_sy), .RD_RSYN_OUT(rd_rs), .CFG_ACCESS_FAULT_OUT(cfg_f),
        .IMPLEMENTED_BANK_COUNT_OUT(nb));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held up between calls; result of each request looked at next edge
    task do_chk(input [2:0] b, input s, input [1:0] k, input [63:0] a, input e);
        {chk_v, chk_b, chk_s2, chk_k, chk_a} = {1'b1, b, s, k, a};
        @(posedge clk);
        #1;
        if (k == 2'h0) check("tfault", tf, e);
        else check("asfault", asf, e);
    endtask
    task rd(input [7:0] b, input ns);
        {sw_rd, sw_b, sw_ns} = {1'b1, b, ns};
        @(posedge clk);
        #1;
        sw_rd = 1'b0;
    endtask
    task clr(input [2:0] b, input [31:0] m);
        {sw_wr, sw_b, sw_d} = {1'b1, 5'h0, b, m};
        m_st[b] = m_st[b] & ~m;
        @(posedge clk);
        #1;
        sw_wr = 1'b0;
    endtask
    task look(input [2:0] b);
        rd({5'h0, b}, 1'b0);
        check("status", rd_st, m_st[b]);
        check("address", rd_ad, m_ad[b]);
        check("syndrome", rd_sy, m_sy[b]);
        if (!m_sy[b][11]) check("rsyn", rd_rs, m_rs[b]);
        check("irq", irq[b], |m_st[b]);
    endtask
    task fault(input [2:0] t, input w, input s, input [2:0] x1, input [2:0] x2,
               input [63:0] a, input int n);
        logic [2:0] b;
        cli.issue(t, w, s, x1, x2, a, n);
        b = s ? x2 : x1;
        check("abort", abort_o, t == 3'h3 && fare[b]);
        repeat (n) begin
            if (m_st[b] != 32'h0) m_st[b][31] = 1'b1;
            else begin
                m_st[b] = 32'h1 << bitpos[t];
                if (t == 3'h2 && !w) {m_ad[b], m_sy[b]} = {64'h0, 32'h800};
                else if (t != 3'h3) begin
                    {m_ad[b], m_rs[b]} = {a, ~a[63:32]};
                    m_sy[b] = {21'h0, w, 5'h0, a[1], 4'h0};
                end
            end
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #(25 * 2000);
        err_count++;
        complete_run;
    end
    initial begin
        logic [63:0] a;
        {hyp, mon, pa, osz, sw_d[3:0]} = rnd();
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int i = 0; i < 12; i++) begin
            a = {rnd(), rnd()} >> (rnd() % 40 + 20);
            do_chk(3'h0, 1'b0, 2'h0, a, |a[63:32]);
            do_chk(3'h0, 1'b1, 2'h0, a, |a[63:36]);
            do_chk(3'h0, 1'b0, 2'h1, a, |a[63:40]);
            do_chk(3'h2, 1'b1, 2'h2, a, |a[63:40]);
            do_chk(3'h1, 1'b0, 2'h0, a, 1'b0);
        end
        chk_v = 1'b0;
        fault(3'h0, 1'b0, 1'b0, 3'h2, 3'h0, a, 2);
        look(3'h2);
        clr(3'h2, 32'h1);
        look(3'h2);
        clr(3'h2, 32'hFFFFFFFF);
        look(3'h2);
        for (int t = 0; t < 5; t++) begin
            fault(t[2:0], t == 2, 1'b1, 3'h4, 3'h3, {rnd(), rnd()}, 1);
            look(3'h3);
            look(3'h4);
            clr(3'h3, 32'hFFFFFFFF);
        end
        fault(3'h2, 1'b0, 1'b0, 3'h6, 3'h0, a, 1);
        look(3'h6);
        fault(3'h3, 1'b0, 1'b0, 3'h5, 3'h0, a, 1);
        fault(3'h3, 1'b0, 1'b0, 3'h6, 3'h0, a, 1);
        look(3'h5);
        look(3'h6);
        ns_cnt = 8'h4;
        rd(8'h6, 1'b1);
        check("ns status", rd_st | rd_rs, 32'h0);
        rd(8'h9, 1'b0);
        check("unimpl", rd_st | rd_rs, 32'h0);
        check("cfg fault", cfg_f, 1'b0);
        check("count", nb, 8'h8);
        complete_run;
    end
endmodule
bind context_fault_recorder fault_rec_sva #(.NUM_BANKS(NUM_BANKS), .BANK_W(BANK_W)) u_sva (.*);
